// File: rtl/bkrg_defines.vh
`ifndef BKRG_DEFINES_VH
`define BKRG_DEFINES_VH

// Register indices; the byte address on the bus is four times the index.
`define BKRG_IDX_BUCK2_CONFIGURATION 6'h39
`define BKRG_IDX_BUCK3_NORMAL_VOLTAGE 6'h3A
`define BKRG_IDX_BUCK3_STANDBY_VOLTAGE 6'h3B
`define BKRG_IDX_BUCK3_SLEEP_VOLTAGE 6'h3C

// Field positions in the buck2 configuration register.
`define BKRG_STEP_RATE_BIT 6
`define BKRG_PHASE_HI 5
`define BKRG_PHASE_LO 4
`define BKRG_FREQ_HI 3
`define BKRG_FREQ_LO 2
`define BKRG_ILIM_BIT 0

// Field position of the buck3 voltage codes.
`define BKRG_VCODE_HI 4
`define BKRG_VCODE_LO 0

// Reset values held until the programmable memory is copied in.
`define BKRG_RST_STEP_RATE 1'h0
`define BKRG_RST_PHASE 2'h0
`define BKRG_RST_FREQ 2'h0
`define BKRG_RST_ILIM 1'h0
`define BKRG_RST_VCODE 5'h00

// Step timing: one 25 mV code step per interval.
`define BKRG_STEP_MV 25
`define BKRG_STEP_FAST_NS 2000
`define BKRG_STEP_SLOW_NS 4000
`define BKRG_CLK_PERIOD_PS 5000
`define BKRG_STEP_FAST_CYC ((`BKRG_STEP_FAST_NS * 1000) / `BKRG_CLK_PERIOD_PS)
`define BKRG_STEP_SLOW_CYC ((`BKRG_STEP_SLOW_NS * 1000) / `BKRG_CLK_PERIOD_PS)

`endif

// File: rtl/bkrg_step_timer.v
`timescale 1ns/1ps
`include "bkrg_defines.vh"

module bkrg_step_timer
(
	input wire sys_clk,
	input wire rstn,
	input wire run,
	input wire slow_sel,
	output wire tick
);

	localparam integer FAST_CYC = `BKRG_STEP_FAST_CYC;
	localparam integer SLOW_CYC = `BKRG_STEP_SLOW_CYC;
	// Both counts fit ten bits; the part-select makes that cut deliberate.
	localparam [9:0] FAST_LAST = FAST_CYC[9:0] - 10'h001;
	localparam [9:0] SLOW_LAST = SLOW_CYC[9:0] - 10'h001;

	reg [9:0] cnt_r;
	reg tick_r;
	wire [9:0] last;

	// The rate is taken live so a rate change applies to the interval already running.
	assign last = slow_sel ? SLOW_LAST : FAST_LAST;
	assign tick = tick_r;

	// Free count while running; restarting on idle keeps the first step a full interval.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_r <= 10'h000;
			tick_r <= 1'h0;
		end
		else if (!run)
		begin
			cnt_r <= 10'h000;
			tick_r <= 1'h0;
		end
		else if (cnt_r >= last)
		begin
			cnt_r <= 10'h000;
			tick_r <= 1'h1;
		end
		else
		begin
			cnt_r <= cnt_r + 10'h001;
			tick_r <= 1'h0;
		end
	end

endmodule

// File: rtl/bkrg_regs.v
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`include "bkrg_defines.vh"

// How it works
// - Bit 6 of buck2 configuration picks one 25 mV step every 2.0 us (0) or 4.0 us (1).
// - Bits 5:4 of buck2 configuration hold the phase clock select and reset to zero.
// - Bits 3:2 of buck2 configuration hold the frequency select, preset from memory.
// - Bit 0 of buck2 configuration picks a 2.75 A (0) or 2.0 A (1) current limit.
// - Buck2 configuration sits at index 0x39 and its bit 7 reads as zero.
// - All four registers are readable and writable at any time, without lock.
// - After reset each configurable field except phase is loaded from the programmable memory.
// - Buck3 normal voltage code is bits 4:0 with bits 7:5 reading zero.
// - Buck3 standby voltage code is bits 4:0 and applies while in standby.
// - Buck3 sleep voltage code is bits 4:0 and applies while in sleep.
module bkrg_regs
#(
	parameter ADR_W = 8,
	parameter CODE_W = 6
)
(
	input wire sys_clk,
	input wire rstn,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [ADR_W-1:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	input wire otp_buck2_step_rate_select,
	input wire [1:0] otp_buck2_frequency_select,
	input wire otp_buck2_current_limit_select,
	input wire [4:0] otp_buck3_normal_voltage_code,
	input wire [4:0] otp_buck3_standby_voltage_code,
	input wire [4:0] otp_buck3_sleep_voltage_code,
	input wire standby_pin,
	input wire sleep_pin,
	input wire [CODE_W-1:0] buck2_target_code,
	output wire buck2_step_rate_select,
	output wire [1:0] buck2_phase_clock_select,
	output wire [1:0] buck2_frequency_select,
	output wire buck2_current_limit_select,
	output wire [4:0] buck3_voltage_code,
	output wire [CODE_W-1:0] buck2_ramp_code,
	output wire buck2_ramp_busy,
	output wire buck2_step_tick,
	output wire otp_load_done
);

	// True when a byte address hits the word register at the given index.
	function reg_hit;
		input [ADR_W-1:0] adr;
		input [5:0] idx;
		begin
			reg_hit = (adr[ADR_W-1:2] == idx[ADR_W-3:0]) && (adr[1:0] == 2'h0);
		end
	endfunction

	// Places a five bit voltage code in the low bits of a bus word.
	function [31:0] vcode_word;
		input [4:0] code;
		begin
			vcode_word = {27'h0000000, code};
		end
	endfunction

	// One code step from the present code toward the target; holds once it is there.
	function [CODE_W-1:0] ramp_step;
		input [CODE_W-1:0] cur;
		input [CODE_W-1:0] tgt;
		begin
			if (cur < tgt)
				ramp_step = cur + {{(CODE_W-1){1'h0}}, 1'h1};
			else if (cur > tgt)
				ramp_step = cur - {{(CODE_W-1){1'h0}}, 1'h1};
			else
				ramp_step = cur;
		end
	endfunction

	reg load_pend_r;
	reg load_done_r;
	reg ack_r;
	reg [31:0] dat_r;
	reg [31:0] dat_nxt;
	reg step_rate_r;
	reg [1:0] phase_r;
	reg [1:0] freq_r;
	reg ilim_r;
	reg [4:0] b3_norm_r;
	reg [4:0] b3_stby_r;
	reg [4:0] b3_sleep_r;
	reg [4:0] b3_applied_r;
	reg [4:0] b3_applied_nxt;
	reg stby_meta_r;
	reg stby_sync_r;
	reg sleep_meta_r;
	reg sleep_sync_r;
	reg [CODE_W-1:0] ramp_r;
	reg busy_r;
	wire bus_req;
	wire take;
	wire wr_lane0;
	wire hit_cfg;
	wire hit_norm;
	wire hit_stby;
	wire hit_sleep;
	wire ramp_tick;

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign buck2_step_rate_select = step_rate_r;
	assign buck2_phase_clock_select = phase_r;
	assign buck2_frequency_select = freq_r;
	assign buck2_current_limit_select = ilim_r;
	assign buck3_voltage_code = b3_applied_r;
	assign buck2_ramp_code = ramp_r;
	assign buck2_ramp_busy = busy_r;
	assign otp_load_done = load_done_r;

	// A request is answered once per cycle pair; ack drops the cycle after it rose.
	assign bus_req = wb_cyc_i & wb_stb_i;
	// Access at any time
	// The only stall is the single load cycle after reset; a request made then is
	// simply taken one edge later, so software never sees a lock.
	assign take = bus_req & ~ack_r & ~load_pend_r;
	assign wr_lane0 = take & wb_we_i & wb_sel_i[0];

	assign hit_cfg = reg_hit(wb_adr_i, `BKRG_IDX_BUCK2_CONFIGURATION);
	assign hit_norm = reg_hit(wb_adr_i, `BKRG_IDX_BUCK3_NORMAL_VOLTAGE);
	assign hit_stby = reg_hit(wb_adr_i, `BKRG_IDX_BUCK3_STANDBY_VOLTAGE);
	assign hit_sleep = reg_hit(wb_adr_i, `BKRG_IDX_BUCK3_SLEEP_VOLTAGE);

	// The memory copy runs in the first cycle after release; the bus waits for it.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			load_pend_r <= 1'h1;
			load_done_r <= 1'h0;
		end
		else
		begin
			load_pend_r <= 1'h0;
			load_done_r <= 1'h1;
		end
	end

	// Buck2 configuration fields: memory copy first, then bus writes.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			step_rate_r <= `BKRG_RST_STEP_RATE;
			phase_r <= `BKRG_RST_PHASE;
			freq_r <= `BKRG_RST_FREQ;
			ilim_r <= `BKRG_RST_ILIM;
		end
		else if (load_pend_r)
		begin
			step_rate_r <= otp_buck2_step_rate_select;
			freq_r <= otp_buck2_frequency_select;
			ilim_r <= otp_buck2_current_limit_select;
			// Phase has no preset and keeps its zero default.
		end
		else if (wr_lane0 && hit_cfg)
		begin
			step_rate_r <= wb_dat_i[`BKRG_STEP_RATE_BIT];
			phase_r <= wb_dat_i[`BKRG_PHASE_HI:`BKRG_PHASE_LO];
			freq_r <= wb_dat_i[`BKRG_FREQ_HI:`BKRG_FREQ_LO];
			ilim_r <= wb_dat_i[`BKRG_ILIM_BIT];
		end
	end

	// Buck3 voltage codes; only bits 4:0 are stored, so upper writes vanish.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			b3_norm_r <= `BKRG_RST_VCODE;
			b3_stby_r <= `BKRG_RST_VCODE;
			b3_sleep_r <= `BKRG_RST_VCODE;
		end
		else if (load_pend_r)
		begin
			b3_norm_r <= otp_buck3_normal_voltage_code;
			b3_stby_r <= otp_buck3_standby_voltage_code;
			b3_sleep_r <= otp_buck3_sleep_voltage_code;
		end
		else if (wr_lane0)
		begin
			if (hit_norm)
				b3_norm_r <= wb_dat_i[`BKRG_VCODE_HI:`BKRG_VCODE_LO];
			if (hit_stby)
				b3_stby_r <= wb_dat_i[`BKRG_VCODE_HI:`BKRG_VCODE_LO];
			if (hit_sleep)
				b3_sleep_r <= wb_dat_i[`BKRG_VCODE_HI:`BKRG_VCODE_LO];
		end
	end

	// Read data; unmapped addresses and reserved bits return zero.
	// Only aligned word addresses decode; a stray byte offset reads as unmapped.
	always @*
	begin
		dat_nxt = 32'h00000000;
		if (hit_cfg)
		begin
			dat_nxt[`BKRG_STEP_RATE_BIT] = step_rate_r;
			dat_nxt[`BKRG_PHASE_HI:`BKRG_PHASE_LO] = phase_r;
			dat_nxt[`BKRG_FREQ_HI:`BKRG_FREQ_LO] = freq_r;
			dat_nxt[`BKRG_ILIM_BIT] = ilim_r;
		end
		else if (hit_norm)
			dat_nxt = vcode_word(b3_norm_r);
		else if (hit_stby)
			dat_nxt = vcode_word(b3_stby_r);
		else if (hit_sleep)
			dat_nxt = vcode_word(b3_sleep_r);
	end

	// Acknowledge one cycle after the request is seen, never two in a row.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			ack_r <= 1'h0;
		else
			ack_r <= take;
	end

	// Read data is captured with the request and held until the next read, so a
	// slow master still finds it stable at the edge where it sees ack.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			dat_r <= 32'h00000000;
		else if (take && !wb_we_i)
			dat_r <= dat_nxt;
	end

	// Mode pins come from outside the clock domain and pass two flip-flops.
	// Standby pin synchroniser
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stby_meta_r <= 1'h0;
			stby_sync_r <= 1'h0;
		end
		else
		begin
			stby_meta_r <= standby_pin;
			stby_sync_r <= stby_meta_r;
		end
	end

	// The pins are unrelated, so each keeps its own pair; only the second flop is read.
	// Sleep pin synchroniser
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sleep_meta_r <= 1'h0;
			sleep_sync_r <= 1'h0;
		end
		else
		begin
			sleep_meta_r <= sleep_pin;
			sleep_sync_r <= sleep_meta_r;
		end
	end

	// Sleep wins over standby since it is the deeper state of the two.
	always @*
	begin
		if (sleep_sync_r)
			b3_applied_nxt = b3_sleep_r;
		else if (stby_sync_r)
			b3_applied_nxt = b3_stby_r;
		else
			b3_applied_nxt = b3_norm_r;
	end

	// Registered so the applied code is a clean flop output; it trails the synchronised pins by one edge.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			b3_applied_r <= `BKRG_RST_VCODE;
		else
			b3_applied_r <= b3_applied_nxt;
	end

	bkrg_step_timer u_step
	(
		.sys_clk(sys_clk),
		.rstn(rstn),
		.run(busy_r),
		.slow_sel(step_rate_r),
		.tick(ramp_tick)
	);

	assign buck2_step_tick = ramp_tick;

	// Buck2 code walks one step per tick toward its target, so the output slews
	// at the selected rate; the jump at load avoids ramping up from zero.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			ramp_r <= {CODE_W{1'h0}};
		else if (load_pend_r)
			ramp_r <= buck2_target_code;
		else if (ramp_tick)
			ramp_r <= ramp_step(ramp_r, buck2_target_code);
	end

	// Busy trails the code by one cycle; the timer restarts when it falls, so a
	// target given while idle always waits a full interval before its first step.
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			busy_r <= 1'h0;
		else if (load_pend_r)
			busy_r <= 1'h0;
		else
			busy_r <= (ramp_r != buck2_target_code);
	end

endmodule

// File: verif/bkrg_regs_checker.sv
`timescale 1ns/1ps
// Watches only the register bank ports; one clock domain.
module bkrg_regs_checker
#(
	parameter ADR_W = 8,
	parameter CODE_W = 6
)
(
	input wire sys_clk,
	input wire rstn,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [ADR_W-1:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire otp_buck2_step_rate_select,
	input wire [1:0] otp_buck2_frequency_select,
	input wire buck2_step_rate_select,
	input wire [1:0] buck2_phase_clock_select,
	input wire [1:0] buck2_frequency_select,
	input wire buck2_current_limit_select,
	input wire [CODE_W-1:0] buck2_target_code,
	input wire [CODE_W-1:0] buck2_ramp_code,
	input wire buck2_ramp_busy,
	input wire buck2_step_tick,
	input wire otp_load_done
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// Busy cycles since the last tick; the tick cycle is the first of the next interval,
	// and idle clears the count so a new ramp starts fresh.
	logic [9:0] gap_r;
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn)
			gap_r <= 10'h000;
		else if (!buck2_ramp_busy)
			gap_r <= 10'h000;
		else if (buck2_step_tick)
			gap_r <= 10'h001;
		else
			gap_r <= gap_r + 10'h001;
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && otp_load_done;
	endsequence
	sequence s_cfg_wr;
		s_req ##0 wb_we_i && wb_sel_i[0] && wb_adr_i == 8'hE4;
	endsequence
	property p_take;
		s_req |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_take: assert property (p_take) else $error("request not acked once");
	property p_rsv;
		wb_dat_o[31:7] == 25'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved read bits set");
	property p_cfg_wr;
		s_cfg_wr |=> {buck2_step_rate_select, buck2_phase_clock_select, buck2_frequency_select,
			buck2_current_limit_select} == {$past(wb_dat_i[6:2]), $past(wb_dat_i[0])};
	endproperty
	a_cfg_wr: assert property (p_cfg_wr) else $error("config fields wrong");
	property p_otp;
		$rose(otp_load_done) |-> buck2_phase_clock_select == 2'h0
			&& buck2_frequency_select == $past(otp_buck2_frequency_select)
			&& buck2_step_rate_select == $past(otp_buck2_step_rate_select);
	endproperty
	a_otp: assert property (p_otp) else $error("preset load wrong");
	property p_busy;
		$past(otp_load_done) |->
			buck2_ramp_busy == ($past(buck2_target_code) != $past(buck2_ramp_code));
	endproperty
	a_busy: assert property (p_busy) else $error("busy mismatch");
	property p_tick;
		buck2_step_tick |-> buck2_ramp_busy ##1 !buck2_step_tick;
	endproperty
	a_tick: assert property (p_tick) else $error("tick not a pulse");
	property p_gap;
		buck2_step_tick |-> gap_r == (buck2_step_rate_select ? 10'h320 : 10'h190);
	endproperty
	a_gap: assert property (p_gap) else $error("step interval wrong");
	property p_idle;
		gap_r <= 10'h320;
	endproperty
	a_idle: assert property (p_idle) else $error("step tick missing");
endmodule
bind bkrg_regs bkrg_regs_checker #(.ADR_W(ADR_W), .CODE_W(CODE_W)) u_bkrg_regs_checker (.*);

// File: verif/bkrg_regs_bench.sv
`timescale 1ns/1ps
module bkrg_regs_bench;
	logic sys_clk = 0;
	logic rstn = 0;
	logic req = 0;
	logic we = 0;
	logic sp = 0;
	logic lp = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] di = 32'h0;
	logic [31:0] rd;
	logic [5:0] tgt = 6'h00;
	// Presets chosen so that every preset field is non-zero and each voltage code is distinct.
	logic o_r = 1'b1;
	logic [1:0] o_f = 2'h2;
	logic o_i = 1'b1;
	logic [4:0] o_n = 5'h11;
	logic [4:0] o_s = 5'h0B;
	logic [4:0] o_l = 5'h16;
	wire [31:0] dq;
	wire ack, rate, ilim, busy, tick, ld;
	wire [1:0] ph, fr;
	wire [4:0] v3;
	wire [5:0] rc;
	int errors = 0;
	int checked = 0;
	bkrg_regs u_bkrg_regs (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(req), .wb_stb_i(req),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(di), .wb_dat_o(dq),
		.wb_ack_o(ack), .otp_buck2_step_rate_select(o_r), .otp_buck2_frequency_select(o_f),
		.otp_buck2_current_limit_select(o_i), .otp_buck3_normal_voltage_code(o_n),
		.otp_buck3_standby_voltage_code(o_s), .otp_buck3_sleep_voltage_code(o_l),
		.standby_pin(sp), .sleep_pin(lp), .buck2_target_code(tgt),
		.buck2_step_rate_select(rate), .buck2_phase_clock_select(ph),
		.buck2_frequency_select(fr), .buck2_current_limit_select(ilim),
		.buck3_voltage_code(v3), .buck2_ramp_code(rc), .buck2_ramp_busy(busy),
		.buck2_step_tick(tick), .otp_load_done(ld));
	// Free-running 200 MHz clock.
	initial
	begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	task final_report(input int hung);
		errors += hung;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// One classic cycle; the request is held until ack is sampled high.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		req <= 1'b1;
		we <= w;
		adr <= a;
		di <= d;
		n = 0;
		@(posedge sys_clk);
		while (ack !== 1'b1)
		begin
			n++;
			if (n > 20)
				final_report(1);
			@(posedge sys_clk);
		end
		rd = dq;
		req <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic t_reset;
		wb(1'h0, 8'hE4, 32'h0);
		chk(rd, {25'h0, o_r, 2'h0, o_f, 1'h0, o_i});
		wb(1'h0, 8'hE8, 32'h0);
		chk(rd, {27'h0, o_n});
		wb(1'h0, 8'hEC, 32'h0);
		chk(rd, {27'h0, o_s});
		wb(1'h0, 8'hF0, 32'h0);
		chk(rd, {27'h0, o_l});
		chk(ph, 2'h0);
		chk(ld, 1'h1);
	endtask
	task automatic t_fields;
		wb(1'h1, 8'hE4, 32'hFFFF_FFFF);
		wb(1'h0, 8'hE4, 32'h0);
		chk(rd, 32'h7D);
		chk({rate, ph, fr, ilim}, 6'h3F);
		for (int i = 0; i < 3; i++)
		begin
			wb(1'h1, 8'hE8 + 8'(4 * i), 32'hFF);
			wb(1'h0, 8'hE8 + 8'(4 * i), 32'h0);
			chk(rd, 32'h1F);
		end
		wb(1'h0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		wb(1'h1, 8'hE4, 32'h0);
		chk({rate, ph, fr, ilim}, 6'h00);
	endtask
	// Mode pins pass a two-flop synchroniser, so four cycles are allowed.
	task automatic t_modes;
		wb(1'h1, 8'hE8, 32'h05);
		wb(1'h1, 8'hEC, 32'h0A);
		wb(1'h1, 8'hF0, 32'h14);
		repeat (4) @(posedge sys_clk);
		chk(v3, 5'h05);
		sp <= 1'h1;
		repeat (4) @(posedge sys_clk);
		chk(v3, 5'h0A);
		lp <= 1'h1;
		repeat (4) @(posedge sys_clk);
		chk(v3, 5'h14);
		sp <= 1'h0;
		lp <= 1'h0;
	endtask
	// Each ramp checks that the code sits one below the new target, then that it rises by one.
	task automatic t_ramp(input logic r, input int per, input logic [5:0] e);
		int n;
		wb(1'h1, 8'hE4, {25'h0, r, 6'h00});
		chk(rc, e - 6'h01);
		tgt <= e;
		n = 0;
		while (tick !== 1'h1)
		begin
			@(posedge sys_clk);
			n++;
			if (n > 1000)
				final_report(1);
		end
		chk(n >= per && n <= per + 2, 32'h1);
		repeat (2) @(posedge sys_clk);
		chk(rc, e);
		chk(busy, 1'h0);
	endtask
	initial
	begin
		repeat (4) @(posedge sys_clk);
		rstn <= 1'h1;
		@(posedge sys_clk);
		t_reset;
		t_fields;
		t_modes;
		t_ramp(1'h0, 400, 6'h01);
		t_ramp(1'h1, 800, 6'h02);
		final_report(0);
	end
endmodule
